// ==== rtc_alarm_pkg.sv ====
// package for the calendar clock calibration and alarm block
// assumes an axi4-lite master with 32-bit data and one clock domain
package rtc_alarm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFS_CALIB = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ALCFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ALARM_MIN_SEC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ALWDHR_VAL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ALMTHDY_VAL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TIME_MINSEC = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TIME_WDHR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TIME_MTHDY = 8'h1c;

  // alarm configuration fields
  localparam int ALCFG_EN_BIT = 15;
  localparam int ALCFG_ENDLESS_REPEAT_BIT = 14;
  localparam int ALCFG_MASK_HI = 13;
  localparam int ALCFG_MASK_LO = 10;
  localparam int ALCFG_RPT_HI = 7;

  // write masks: unimplemented bits stay zero
  localparam logic [15:0] MINSEC_MASK = 16'h7f7f;
  localparam logic [15:0] WDHR_MASK = 16'h073f;
  localparam logic [15:0] MTHDY_MASK = 16'h1f3f;
  localparam logic [15:0] CALIB_MASK = 16'h00ff;
  localparam logic [15:0] ALCFG_MASK = 16'hfcff;

  // digit-field masks for the compare
  localparam logic [15:0] SEC_ONES_F = 16'h000f;
  localparam logic [15:0] SEC_ALL_F = 16'h007f;
  localparam logic [15:0] MIN_TENS_F = 16'h7000;
  localparam logic [15:0] MIN_ALL_F = 16'h7f00;
  localparam logic [15:0] HOUR_F = 16'h003f;
  localparam logic [15:0] WDAY_F = 16'h0700;
  localparam logic [15:0] DAY_F = 16'h003f;
  localparam logic [15:0] MONTH_F = 16'h1f00;
  localparam logic [15:0] FEB29 = 16'h0229;

  localparam logic [7:0] RPT_ALL_ONES = 8'hff;
  localparam logic [7:0] RPT_ZERO = 8'h00;
  localparam int CAL_SCALE_SHIFT = 2;
  localparam logic [15:0] ZERO16 = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    MASK_HALF_SEC = 4'h0,
    MASK_SEC = 4'h1,
    MASK_TEN_SEC = 4'h2,
    MASK_MIN = 4'h3,
    MASK_TEN_MIN = 4'h4,
    MASK_HOUR = 4'h5,
    MASK_DAY = 4'h6,
    MASK_WEEK = 4'h7,
    MASK_MONTH = 4'h8,
    MASK_YEAR = 4'h9
  } alarm_mask_t;

  // current time digits from the neighbouring timekeeping counters
  typedef struct packed {
    logic [15:0] mthdy;
    logic [15:0] wdhr;
    logic [15:0] minsec;
  } time_digits_t;

  // calibration command to the timer: signed pulse correction per minute
  typedef struct packed {
    logic valid;
    logic [9:0] pulses;
  } cal_cmd_t;

endpackage : rtc_alarm_pkg

// ==== rtc_calibration_and_alarm.sv ====
// calibration and alarm unit of a bcd calendar clock, axi4-lite slave
// assumes time digits, half-second and minute ticks come from the timer,
// already in this clock domain; the timer applies the correction pulses
module rtc_calibration_and_alarm
  import rtc_alarm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire time_digits_t TIME_I,
  input wire logic HALF_SEC_TICK_I,
  input wire logic MINUTE_TICK_I,
  output cal_cmd_t CAL_CMD_O,
  output logic ALARM_IRQ_O,
  output logic ALARM_PULSE_O
);

  logic [15:0] calib;
  logic [15:0] alcfg;
  logic [15:0] al_minsec;
  logic [15:0] al_wdhr;
  logic [15:0] al_mthdy;

  logic [ADDR_W-1:0] awaddr;
  logic [DATA_W-1:0] wdata;
  logic [3:0] wstrb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic wr_hit;
  logic [15:0] wr_lo;
  logic [15:0] rd_val;
  logic rd_hit;

  logic alarm_en;
  logic endless_repeat;
  logic [3:0] mask_code;
  logic [7:0] rpt;
  logic [15:0] m_minsec;
  logic [15:0] m_wdhr;
  logic [15:0] m_mthdy;
  logic match;
  logic code_ok;
  logic alarm_evt;
  logic last_alarm;

  assign alarm_en = alcfg[ALCFG_EN_BIT];
  assign endless_repeat = alcfg[ALCFG_ENDLESS_REPEAT_BIT];
  assign mask_code = alcfg[ALCFG_MASK_HI:ALCFG_MASK_LO];
  assign rpt = alcfg[ALCFG_RPT_HI:0];

  // ---------------- axi4-lite write path
  // address and data are latched independently, in either order
  assign do_write = aw_held && w_held && !S_AXI_BVALID_O;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_held <= 1'b0;
      awaddr <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      awaddr <= S_AXI_AWADDR_I;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      w_held <= 1'b0;
      wdata <= '0;
      wstrb <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      wdata <= S_AXI_WDATA_I;
      wstrb <= S_AXI_WSTRB_I;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_held && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O)
                         && !S_AXI_BVALID_O;
      S_AXI_WREADY_O <= !w_held && !(S_AXI_WVALID_I && S_AXI_WREADY_O)
                        && !S_AXI_BVALID_O;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    case (awaddr)
      OFS_CALIB, OFS_ALCFG, OFS_ALARM_MIN_SEC,
      OFS_ALWDHR_VAL, OFS_ALMTHDY_VAL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0] be,
                                        input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = nw[7:0];
    if (be[1]) r[15:8] = nw[15:8];
    return r & msk;
  endfunction : merge

  assign wr_lo = wdata[15:0];

  // ---------------- value registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      calib <= ZERO16;
    end else if (do_write && awaddr == OFS_CALIB) begin
      calib <= merge(calib, wr_lo, wstrb[1:0], CALIB_MASK);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      al_minsec <= ZERO16;
      al_wdhr <= ZERO16;
      al_mthdy <= ZERO16;
    end else if (do_write) begin
      if (awaddr == OFS_ALARM_MIN_SEC) begin
        al_minsec <= merge(al_minsec, wr_lo, wstrb[1:0], MINSEC_MASK);
      end
      if (awaddr == OFS_ALWDHR_VAL) begin
        al_wdhr <= merge(al_wdhr, wr_lo, wstrb[1:0], WDHR_MASK);
      end
      if (awaddr == OFS_ALMTHDY_VAL) begin
        al_mthdy <= merge(al_mthdy, wr_lo, wstrb[1:0], MTHDY_MASK);
      end
    end
  end

  // ---------------- alarm compare
  always_comb begin
    m_minsec = ZERO16;
    m_wdhr = ZERO16;
    m_mthdy = ZERO16;
    code_ok = 1'b1;
    case (alarm_mask_t'(mask_code))
      MASK_HALF_SEC, MASK_SEC: ;
      MASK_TEN_SEC: m_minsec = SEC_ONES_F;
      MASK_MIN: m_minsec = SEC_ALL_F;
      MASK_TEN_MIN: m_minsec = SEC_ALL_F | (MIN_ALL_F & ~MIN_TENS_F);
      MASK_HOUR: m_minsec = SEC_ALL_F | MIN_ALL_F;
      MASK_DAY: begin
        m_minsec = SEC_ALL_F | MIN_ALL_F;
        m_wdhr = HOUR_F;
      end
      MASK_WEEK: begin
        m_minsec = SEC_ALL_F | MIN_ALL_F;
        m_wdhr = HOUR_F | WDAY_F;
      end
      MASK_MONTH: begin
        m_minsec = SEC_ALL_F | MIN_ALL_F;
        m_wdhr = HOUR_F;
        m_mthdy = DAY_F;
      end
      MASK_YEAR: begin
        m_minsec = SEC_ALL_F | MIN_ALL_F;
        m_wdhr = HOUR_F;
        m_mthdy = DAY_F | MONTH_F;
      end
      // a field mask alone could still match equal digits, so gate it
      default: code_ok = 1'b0;
    endcase
  end

  // every unmasked digit equals its alarm value
  assign match = ((TIME_I.minsec & m_minsec) == (al_minsec & m_minsec))
              && ((TIME_I.wdhr & m_wdhr) == (al_wdhr & m_wdhr))
              && ((TIME_I.mthdy & m_mthdy) == (al_mthdy & m_mthdy))
              && code_ok
              && !(mask_code == MASK_YEAR && al_mthdy == FEB29);

  // half-second and second codes fire on every tick; the others only when
  // the compared digits match, so ticks are evaluated on the half-second grid
  assign alarm_evt = alarm_en && HALF_SEC_TICK_I && match;
  assign last_alarm = (rpt == RPT_ZERO) && !endless_repeat;

  // ---------------- alarm configuration and repeat counter
  // a hardware update wins over a simultaneous software write
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      alcfg <= ZERO16;
    end else if (alarm_evt) begin
      if (last_alarm) begin
        alcfg[ALCFG_EN_BIT] <= 1'b0;
      end else if (rpt == RPT_ZERO) begin
        alcfg[ALCFG_RPT_HI:0] <= RPT_ALL_ONES;
      end else begin
        alcfg[ALCFG_RPT_HI:0] <= rpt - 8'h01;
      end
    end else if (do_write && awaddr == OFS_ALCFG) begin
      alcfg <= merge(alcfg, wr_lo, wstrb[1:0], ALCFG_MASK);
    end
  end

  // ---------------- alarm outputs
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ALARM_IRQ_O <= 1'b0;
      ALARM_PULSE_O <= 1'b0;
    end else begin
      ALARM_IRQ_O <= alarm_evt;
      if (alarm_evt) begin
        ALARM_PULSE_O <= !ALARM_PULSE_O;
      end
    end
  end

  // ---------------- calibration command, once per minute
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      CAL_CMD_O <= '0;
    end else begin
      CAL_CMD_O.valid <= MINUTE_TICK_I && (calib[7:0] != RPT_ZERO);
      CAL_CMD_O.pulses <= {{2{calib[7]}}, calib[7:0]} << CAL_SCALE_SHIFT;
    end
  end

  // ---------------- axi4-lite read path
  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR_I)
      OFS_CALIB: rd_val = calib;
      OFS_ALCFG: rd_val = alcfg;
      OFS_ALARM_MIN_SEC: rd_val = al_minsec;
      OFS_ALWDHR_VAL: rd_val = al_wdhr;
      OFS_ALMTHDY_VAL: rd_val = al_mthdy;
      OFS_TIME_MINSEC: rd_val = TIME_I.minsec;
      OFS_TIME_WDHR: rd_val = TIME_I.wdhr;
      OFS_TIME_MTHDY: rd_val = TIME_I.mthdy;
      default: begin
        rd_val = ZERO16;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      S_AXI_ARREADY_O <= 1'b0;
    end else begin
      S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !S_AXI_ARREADY_O;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= '0;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= {ZERO16, rd_val};
      S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule : rtc_calibration_and_alarm

// ==== rtc_alarm_assertions.sv ====
// concurrent checks on the calibration and alarm outputs
// sees only the top module ports; attached by the bind at the foot
module rtc_alarm_checker
  import rtc_alarm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic HALF_SEC_TICK_I,
  input wire logic MINUTE_TICK_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic [DATA_W-1:0] S_AXI_RDATA_O,
  input wire cal_cmd_t CAL_CMD_O,
  input wire logic ALARM_IRQ_O,
  input wire logic ALARM_PULSE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  AST_IRQ_ONE: assert property (ALARM_IRQ_O |=> !ALARM_IRQ_O)
    else $error("alarm request wider than one cycle");
  AST_IRQ_TICK: assert property (ALARM_IRQ_O |-> $past(HALF_SEC_TICK_I))
    else $error("alarm request without a half second tick");
  AST_PULSE_FLIP: assert property (ALARM_IRQ_O |->
    ALARM_PULSE_O != $past(ALARM_PULSE_O))
    else $error("alarm pulse did not toggle on an alarm");
  AST_PULSE_HOLD: assert property (!ALARM_IRQ_O |-> $stable(ALARM_PULSE_O))
    else $error("alarm pulse moved without an alarm");
  AST_CAL_TICK: assert property (CAL_CMD_O.valid |-> $past(MINUTE_TICK_I))
    else $error("correction issued without a minute tick");
  AST_CAL_ONE: assert property (CAL_CMD_O.valid |=> !CAL_CMD_O.valid)
    else $error("correction issued twice in a row");
  AST_CAL_X4: assert property (CAL_CMD_O.valid |->
    CAL_CMD_O.pulses[1:0] == 2'b00)
    else $error("correction not a multiple of four");
  AST_CAL_NZ: assert property (CAL_CMD_O.valid |->
    CAL_CMD_O.pulses != 10'h000)
    else $error("correction issued for a zero value");
  AST_RD_HI: assert property (S_AXI_RVALID_O |->
    S_AXI_RDATA_O[31:16] == 16'h0000)
    else $error("unused read data bits not zero");
  cover property (ALARM_IRQ_O);
  cover property (CAL_CMD_O.valid);
  cover property (S_AXI_RVALID_O);
endmodule : rtc_alarm_checker

bind rtc_calibration_and_alarm rtc_alarm_checker i_chk (
  .CLOCK_I(CLOCK_I),
  .RESET_I(RESET_I),
  .HALF_SEC_TICK_I(HALF_SEC_TICK_I),
  .MINUTE_TICK_I(MINUTE_TICK_I),
  .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .CAL_CMD_O(CAL_CMD_O),
  .ALARM_IRQ_O(ALARM_IRQ_O),
  .ALARM_PULSE_O(ALARM_PULSE_O)
);

// ==== tb_top.sv ====
// self-checking bench for the calibration and alarm block
// drives axi4-lite, time digits and ticks; reads are checked off a queue
module tb_top
  import rtc_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rst = '1, awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
  logic hs = '0, mt = '0, awr, wrdy, bv, arr, rv, irq, pls;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [3:0] ws = '0;
  logic [1:0] bresp, rresp;
  time_digits_t tm = '0;
  cal_cmd_t cal;
  logic [33:0] expq[$];
  logic [15:0] d;
  logic [7:0] cv[5] = '{8'h05, 8'hfd, 8'h80, 8'h7f, 8'h00};
  int off[8] = '{0, 4, 8, 12, 16, 24, 32, 40};
  int bad_count = 0, checks_done = 0, cyc = 0, nirq = 0, ea = 0;
  int seed = 32'h8696c93c;

  always #12.5 clk = ~clk;

  rtc_calibration_and_alarm i_dut (.CLOCK_I(clk), .RESET_I(rst),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .TIME_I(tm),
    .HALF_SEC_TICK_I(hs), .MINUTE_TICK_I(mt), .CAL_CMD_O(cal),
    .ALARM_IRQ_O(irq), .ALARM_PULSE_O(pls));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [33:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // each source holds valid until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    input logic [3:0] s, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= {16'h0000, v};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wrdy === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end while (!(ad && dd));
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    check("bresp", 34'(bresp), 34'(er));
  endtask : wr

  task automatic rdr(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    expq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
  endtask : rdr

  task automatic tick(input int n, input int e);
    int c0;
    c0 = nirq;
    ea += e;
    repeat (n) begin
      @(posedge clk);
      hs <= 1'b1;
      @(posedge clk);
      hs <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check("alarms", 34'(nirq - c0), 34'(e));
    check("pulse", 34'(pls), 34'(ea % 2));
  endtask : tick

  task automatic calt(input logic [7:0] v);
    wr(OFS_CALIB, {8'h00, v}, 4'h1, RESP_OKAY);
    @(posedge clk);
    mt <= 1'b1;
    @(posedge clk);
    mt <= 1'b0;
    #1;
    check("cal", 34'(cal), 34'({v != 8'h00, 10'($signed(v) * 4)}));
  endtask : calt

  // read results are compared here as they appear
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) nirq++;
    if (rv === 1'b1 && rr === 1'b1) begin
      check("rdata", {rresp, rd}, expq.pop_front());
    end
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rdr(8'(4 * i), '0);
    tm <= 48'h1234;
    rdr(OFS_TIME_MINSEC, 34'h1234);
    rdr(8'h40, {RESP_SLVERR, 32'h0});
    wr(8'h40, 16'hffff, 4'h3, RESP_SLVERR);
    repeat (4) begin
      d = 16'($random(seed));
      wr(OFS_ALARM_MIN_SEC, d, 4'h3, RESP_OKAY);
      rdr(OFS_ALARM_MIN_SEC, {18'h0, d & 16'h7f7f});
    end
    wr(OFS_ALARM_MIN_SEC, 16'h0000, 4'h3, RESP_OKAY);
    wr(OFS_ALARM_MIN_SEC, 16'hffff, 4'h2, RESP_OKAY);
    rdr(OFS_ALARM_MIN_SEC, 34'h7f00);
    wr(OFS_ALARM_MIN_SEC, 16'h0000, 4'h3, RESP_OKAY);
    foreach (cv[i]) calt(cv[i]);
    tm <= '0;
    wr(OFS_ALCFG, 16'h8402, 4'h3, RESP_OKAY);
    tick(5, 3);
    rdr(OFS_ALCFG, 34'h0400);
    wr(OFS_ALCFG, 16'h8400, 4'h3, RESP_OKAY);
    tick(3, 1);
    wr(OFS_ALCFG, 16'h84ff, 4'h3, RESP_OKAY);
    tick(260, 256);
    wr(OFS_ALCFG, 16'hc401, 4'h3, RESP_OKAY);
    tick(5, 5);
    rdr(OFS_ALCFG, 34'hc4fc);
    wr(OFS_ALCFG, 16'h0000, 4'h3, RESP_OKAY);
    wr(OFS_ALMTHDY_VAL, 16'h0229, 4'h3, RESP_OKAY);
    tm <= {16'h0229, 32'h0};
    wr(OFS_ALCFG, 16'ha400, 4'h3, RESP_OKAY);
    tick(2, 0);
    wr(OFS_ALCFG, 16'h0000, 4'h3, RESP_OKAY);
    wr(OFS_ALMTHDY_VAL, 16'h0000, 4'h3, RESP_OKAY);
    // fire with only the next field off, miss with the new field off
    for (int k = 0; k < 10; k++) begin
      for (int f = 0; f < ((k < 2) ? 1 : 2); f++) begin
        if (f == 0) tm <= (k == 9) ? '0 : 48'h1 << off[(k == 0) ? 0 : k - 1];
        else tm <= 48'h1 << off[k - 2];
        wr(OFS_ALCFG, 16'h8000 | (16'(k) << 10), 4'h3, RESP_OKAY);
        tick(1, int'(f == 0));
        wr(OFS_ALCFG, 16'h0000, 4'h3, RESP_OKAY);
      end
    end
    // undefined mask code with every digit equal must stay silent
    tm <= '0;
    wr(OFS_ALCFG, 16'ha800, 4'h3, RESP_OKAY);
    tick(1, 0);
    // reset in mid-run clears the configuration and the pulse level
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check("pulse", 34'(pls), 34'(0));
    rdr(OFS_ALCFG, '0);
    finish_test();
  end
endmodule : tb_top
